// File: inc/scsp_defines.svh
// Constants of the serial command slave port: frame layout, sizes, timing
`ifndef SCSP_DEFINES_SVH
`define SCSP_DEFINES_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define SCSP_FRAME_BITS  32
`define SCSP_OP_MSB      31
`define SCSP_OP_LSB      24
`define SCSP_ADDR_MSB    23
`define SCSP_ADDR_LSB    16
`define SCSP_DATA_MSB    15
`define SCSP_DATA_LSB    0
`define SCSP_ECHO_DELAY  8
`define SCSP_HDR_EDGES   16
`define SCSP_CNT_W       6

// ----------------------------------------------------------------
// Storage sizes and reset values
// ----------------------------------------------------------------
`define SCSP_REG_N       16
`define SCSP_MEM_N       32
`define SCSP_FIFO_DEPTH  16
`define SCSP_REG_RST     16'h0000
`define SCSP_MEM_RST     16'h0000
`define SCSP_ERASED      16'hffff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCSP_CLK_NS      10
`define SCSP_SCLK_MIN_NS 8000
`define SCSP_HALF_CYC    ((`SCSP_SCLK_MIN_NS + 2 * `SCSP_CLK_NS - 1) / (2 * `SCSP_CLK_NS))
`define SCSP_TMR_W       10

`endif

// File: inc/scsp_if.sv
// Link wires between the serial master and the command slave port
`timescale 1ns/1ns
`default_nettype none
interface scsp_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;

  modport slave  (input sclk, input cs_n, input sdi, output sdo);
  modport master (output sclk, output cs_n, output sdi, input sdo);
endinterface
`default_nettype wire

// File: inc/scsp_pkg.sv
// Types used by the slave end of the serial command slave port and by the bench
`default_nettype none
package scsp_pkg;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    scsp_no_op          = 3'h0,
    scsp_reg_write_op   = 3'h1,
    scsp_reg_read_op    = 3'h2,
    mem_word_write_op   = 3'h3,
    mem_erase_op        = 3'h4,
    mem_read_op         = 3'h5,
    mem_block_write_op  = 3'h6,
    mem_block_erase_op  = 3'h7
  } scsp_op_t;

  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  addr;
    logic [15:0] data;
  } scsp_frame_t;

  function automatic scsp_op_t scsp_decode(input logic [7:0] c);
    scsp_op_t r;
    r = scsp_no_op;
    casez (c)
      8'b?101?0??: r = scsp_reg_write_op;
      8'b?10010??: r = scsp_reg_read_op;
      8'b0001????: r = mem_word_write_op;
      8'b001?????: r = mem_erase_op;
      8'b?0001???: r = mem_read_op;
      8'b1001????: r = mem_block_write_op;
      8'b101?????: r = mem_block_erase_op;
      default:     r = scsp_no_op;
    endcase
    return r;
  endfunction

endpackage
`default_nettype wire

// File: logic/scsp_master.sv
// Serial master end: makes the link clock by dividing clk, frames commands
`timescale 1ns/1ns
`default_nettype none
`include "scsp_defines.svh"

module scsp_master (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  scsp_if.master           link,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [7:0]  cmd_op,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [15:0] cmd_data,
  input  wire logic [5:0]  cmd_bits,
  output logic             rsp_valid,
  output logic [31:0]      rsp_word
);
  typedef enum logic [1:0] {
    scsp_m_idle = 2'b00,
    scsp_m_low  = 2'b01,
    scsp_m_high = 2'b10,
    scsp_m_gap  = 2'b11
  } scsp_mst_t;

  typedef struct packed {
    scsp_mst_t              st;
    logic [`SCSP_TMR_W-1:0] tmr;
    logic [`SCSP_CNT_W-1:0] n;
    logic [`SCSP_CNT_W-1:0] len;
    logic [31:0]            tx;
    logic [31:0]            rx;
    logic [1:0]             sdo_s;
    logic                   sclk;
    logic                   cs_n;
    logic                   sdi;
    logic                   ready;
    logic                   rsp;
  } scsp_mst_st_t;

  localparam logic [`SCSP_TMR_W-1:0] HALF = `SCSP_TMR_W'(`SCSP_HALF_CYC - 1);

  scsp_mst_st_t s_q;
  scsp_mst_st_t s_d;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.sdo_s = {s_q.sdo_s[0], link.sdo};
    s_d.rsp   = 1'b0;
    if (s_q.tmr != '0) begin
      s_d.tmr = s_q.tmr - 1'b1;
    end
    unique case (s_q.st)
      scsp_m_idle: begin
        if (cmd_valid && s_q.ready) begin
          s_d.tx    = {cmd_op, cmd_addr, cmd_data};
          s_d.len   = cmd_bits;
          s_d.n     = '0;
          s_d.cs_n  = 1'b0;
          s_d.sdi   = cmd_op[7];
          s_d.ready = 1'b0;
          s_d.tmr   = HALF;
          s_d.st    = scsp_m_low;
        end
      end
      scsp_m_low: begin
        if (s_q.tmr == '0) begin
          if (s_q.n >= s_q.len) begin
            // Short count aborts the command at the slave
            s_d.cs_n     = 1'b1;
            s_d.rsp      = 1'b1;
            s_d.tmr      = HALF;
            s_d.st       = scsp_m_gap;
          end else begin
            s_d.sclk = 1'b1;
            s_d.rx   = {s_q.rx[30:0], s_q.sdo_s[1]};
            s_d.n    = s_q.n + 1'b1;
            s_d.tmr  = HALF;
            s_d.st   = scsp_m_high;
          end
        end
      end
      scsp_m_high: begin
        if (s_q.tmr == '0) begin
          s_d.sclk = 1'b0;
          s_d.tx   = {s_q.tx[30:0], 1'b0};
          s_d.sdi  = s_q.tx[30];
          s_d.tmr  = HALF;
          s_d.st   = scsp_m_low;
        end
      end
      scsp_m_gap: begin
        // Select stays high long enough for the slave to see it
        if (s_q.tmr == '0) begin
          s_d.ready = 1'b1;
          s_d.st    = scsp_m_idle;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q       <= '0;
      s_q.cs_n  <= 1'b1;
      s_q.ready <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign link.sclk = s_q.sclk;
  assign link.cs_n = s_q.cs_n;
  assign link.sdi  = s_q.sdi;
  assign cmd_ready = s_q.ready;
  assign rsp_valid = s_q.rsp;
  assign rsp_word  = s_q.rx;
endmodule
`default_nettype wire

// File: logic/scsp_slave.sv
// Command slave port: serial front end on the link clock, executor on clk
`timescale 1ns/1ns
`default_nettype none
`include "scsp_defines.svh"

// ----------------------------------------------------------------
// FIFO
// ----------------------------------------------------------------
module scsp_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } scsp_fifo_st_t;

  scsp_fifo_st_t s_q;
  scsp_fifo_st_t s_d;
  logic          push;
  logic          pop;

  assign in_ready  = (s_q.cnt != (AW+1)'(D));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp          = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule

// ----------------------------------------------------------------
// Slave port
// ----------------------------------------------------------------
module scsp_slave (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  scsp_if.slave                  link,
  input  wire logic              exec_ready,
  output logic                   exec_pulse,
  output scsp_pkg::scsp_op_t     exec_kind,
  output logic [7:0]             exec_addr,
  output logic [15:0]            exec_data
);
  // Frame state lives only while select is low
  typedef struct packed {
    logic [`SCSP_CNT_W-1:0] cnt;
    logic [31:0]            sh;
  } scsp_frm_t;

  // Hand-off state persists across frames
  typedef struct packed {
    logic        done_tgl;
    logic        rdq_tgl;
    logic [7:0]  hdr_op;
    logic [7:0]  hdr_addr;
    logic [31:0] word;
  } scsp_hnd_t;

  typedef struct packed {
    logic [2:0]                               done_s;
    logic [2:0]                               rdq_s;
    logic [1:0]                               cs_s;
    logic                                     pend;
    logic [31:0]                              pframe;
    logic [15:0]                              rd_word;
    logic [`SCSP_REG_N-1:0][15:0]             regs;
    logic [`SCSP_MEM_N-1:0][15:0]             mem;
    logic                                     pulse;
    scsp_pkg::scsp_op_t                       kind;
    logic [7:0]                               addr;
    logic [15:0]                              data;
  } scsp_sys_t;

  scsp_frm_t          f_q;
  scsp_frm_t          f_d;
  scsp_hnd_t          h_q;
  scsp_hnd_t          h_d;
  scsp_sys_t          s_q;
  scsp_sys_t          s_d;
  logic               sdo_q;
  logic               sdo_d;
  logic               frm_rst_n;
  logic [31:0]        sh_nx;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic [31:0]        fifo_out_data;
  logic               push;
  logic               pop;
  scsp_pkg::scsp_frame_t  cmd;
  scsp_pkg::scsp_op_t     cmd_kind;
  scsp_pkg::scsp_op_t     hdr_kind;

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------
  // Select high ends the frame without any clock edge
  assign frm_rst_n = rst_n && !link.cs_n;
  assign sh_nx     = {f_q.sh[30:0], link.sdi};
  assign hdr_kind  = scsp_pkg::scsp_decode(h_q.hdr_op);

  always_comb begin
    f_d     = f_q;
    f_d.sh  = sh_nx;
    if (f_q.cnt != `SCSP_CNT_W'(`SCSP_FRAME_BITS)) begin
      f_d.cnt = f_q.cnt + 1'b1;
    end
  end

  always_comb begin
    h_d = h_q;
    if (f_q.cnt == `SCSP_CNT_W'(`SCSP_HDR_EDGES - 1)) begin
      h_d.hdr_op   = sh_nx[15:8];
      h_d.hdr_addr = sh_nx[7:0];
      h_d.rdq_tgl  = !h_q.rdq_tgl;
    end
    // Only the 32nd edge completes a frame; shorter ones never toggle
    if (f_q.cnt == `SCSP_CNT_W'(`SCSP_FRAME_BITS - 1)) begin
      h_d.word     = sh_nx;
      h_d.done_tgl = !h_q.done_tgl;
    end
  end

  // Falling edge gives the output half a period of margin
  always_comb begin
    sdo_d = 1'b0;
    if ((hdr_kind == scsp_pkg::scsp_reg_read_op || hdr_kind == scsp_pkg::mem_read_op)
        && f_q.cnt >= `SCSP_CNT_W'(`SCSP_HDR_EDGES)
        && f_q.cnt < `SCSP_CNT_W'(`SCSP_FRAME_BITS)) begin
      sdo_d = s_q.rd_word[4'(5'h1f - 5'(f_q.cnt))];
    end else if (f_q.cnt >= `SCSP_CNT_W'(`SCSP_ECHO_DELAY)
                 && f_q.cnt < `SCSP_CNT_W'(`SCSP_FRAME_BITS)) begin
      sdo_d = f_q.sh[`SCSP_ECHO_DELAY-1];
    end
  end

  always_ff @(posedge link.sclk or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      h_q <= '0;
    end else begin
      h_q <= h_d;
    end
  end

  always_ff @(negedge link.sclk or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= sdo_d;
    end
  end

  assign link.sdo = sdo_q;

  // ----------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------
  assign push     = s_q.pend && s_q.cs_s[1] && fifo_in_ready;
  assign pop      = fifo_out_valid && exec_ready;
  assign cmd      = scsp_pkg::scsp_frame_t'(fifo_out_data);
  assign cmd_kind = scsp_pkg::scsp_decode(cmd.op);

  always_comb begin
    s_d        = s_q;
    s_d.done_s = {s_q.done_s[1:0], h_q.done_tgl};
    s_d.rdq_s  = {s_q.rdq_s[1:0], h_q.rdq_tgl};
    s_d.cs_s   = {s_q.cs_s[0], link.cs_n};
    s_d.pulse  = 1'b0;
    // Word is stable for a whole frame after its toggle
    if (s_q.done_s[2] != s_q.done_s[1]) begin
      s_d.pend   = 1'b1;
      s_d.pframe = h_q.word;
    end else if (push) begin
      s_d.pend = 1'b0;
    end
    // Answer well inside half a serial period
    if (s_q.rdq_s[2] != s_q.rdq_s[1]) begin
      unique case (scsp_pkg::scsp_decode(h_q.hdr_op))
        scsp_pkg::scsp_reg_read_op: s_d.rd_word = s_q.regs[h_q.hdr_addr[3:0]];
        scsp_pkg::mem_read_op:      s_d.rd_word = s_q.mem[h_q.hdr_addr[4:0]];
        default:                    s_d.rd_word = 16'h0000;
      endcase
    end
    if (pop) begin
      s_d.pulse = 1'b1;
      s_d.kind  = cmd_kind;
      s_d.addr  = cmd.addr;
      s_d.data  = cmd.data;
      unique case (cmd_kind)
        scsp_pkg::scsp_reg_write_op: s_d.regs[cmd.addr[3:0]] = cmd.data;
        scsp_pkg::mem_word_write_op: s_d.mem[cmd.addr[4:0]]  = cmd.data;
        scsp_pkg::mem_erase_op:      s_d.mem[cmd.addr[4:0]]  = `SCSP_ERASED;
        scsp_pkg::mem_block_write_op: begin
          for (int i = 0; i < `SCSP_MEM_N; i++) begin
            s_d.mem[i] = cmd.data;
          end
        end
        scsp_pkg::mem_block_erase_op: begin
          for (int i = 0; i < `SCSP_MEM_N; i++) begin
            s_d.mem[i] = `SCSP_ERASED;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q      <= '0;
      s_q.cs_s <= 2'h3;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Holds up to 16 whole frames plus one pending, so a stalled executor loses nothing until a later frame overwrites that pending one
  scsp_fifo #(
    .W (`SCSP_FRAME_BITS),
    .D (`SCSP_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (s_q.pend && s_q.cs_s[1]),
    .in_ready  (fifo_in_ready),
    .in_data   (s_q.pframe),
    .out_valid (fifo_out_valid),
    .out_ready (exec_ready),
    .out_data  (fifo_out_data)
  );

  assign exec_pulse = s_q.pulse;
  assign exec_kind  = s_q.kind;
  assign exec_addr  = s_q.addr;
  assign exec_data  = s_q.data;
endmodule
`default_nettype wire

// File: verification/scsp_link_asserts.sv
// Link checker for the serial command slave port
`timescale 1ns/1ns
`default_nettype none
module scsp_link_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo
);
  // --------
  // Helpers
  // --------
  logic [5:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] op_q;
  logic [9:0] hc_q;
  logic       sclk_q;
  logic       rd;

  // Edge count in frame, cleared by select like the slave's own logic
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= 6'h00;
      sh_q  <= 8'h00;
      op_q  <= 8'h00;
    end else begin
      if (cnt_q != 6'h3f) begin
        cnt_q <= cnt_q + 6'h01;
      end
      sh_q <= {sh_q[6:0], sdi};
      if (cnt_q == 6'h07) begin
        op_q <= {sh_q[6:0], sdi};
      end
    end
  end

  assign rd = (op_q ==? 8'b?10010??) || (op_q ==? 8'b?0001???);

  // Saturates so the first edge of a frame never looks short
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      hc_q   <= 10'h000;
    end else begin
      sclk_q <= sclk;
      hc_q   <= (sclk != sclk_q) ? 10'h000 : ((hc_q == 10'h3ff) ? hc_q : hc_q + 10'h001);
    end
  end

  // --------
  // Properties
  // --------
  sequence s_open;
    $fell(cs_n);
  endsequence

  sequence s_head;
    cnt_q >= 6'h08 && cnt_q < 6'h10;
  endsequence

  a_sclk_idle_desel: assert property (@(posedge clk) disable iff (!rst_n)
    cs_n |-> !sclk) else $error("link clock runs while deselected");
  a_cs_open_setup: assert property (@(posedge clk) disable iff (!rst_n)
    s_open |-> !sclk [*8]) else $error("clock rises too soon after select");
  a_half_period_min: assert property (@(posedge clk) disable iff (!rst_n)
    (sclk != sclk_q) && !cs_n |-> hc_q >= 10'h18f) else $error("link clock too fast");
  a_sdi_hold_high: assert property (@(posedge clk) disable iff (!rst_n)
    sclk && !cs_n |-> $stable(sdi)) else $error("input bit moved while clock high");
  a_sdo_valid_rise: assert property (@(posedge clk) disable iff (!rst_n)
    sclk |-> $stable(sdo)) else $error("output bit moved while clock high");
  a_sdo_rest_desel: assert property (@(posedge clk) disable iff (!rst_n)
    cs_n |-> !sdo) else $error("output not low while deselected");
  a_echo_quiet_head: assert property (@(posedge sclk) disable iff (cs_n)
    cnt_q < 6'h08 |-> !sdo) else $error("output not low before echo");
  a_echo_op_head: assert property (@(posedge sclk) disable iff (cs_n)
    s_head |-> sdo == $past(sdi, 8)) else $error("opcode echo wrong");
  a_echo_write_tail: assert property (@(posedge sclk) disable iff (cs_n)
    cnt_q >= 6'h10 && cnt_q < 6'h20 && !rd |-> sdo == $past(sdi, 8))
    else $error("write echo wrong");
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench: master and slave ends joined over the link
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic               clk;
  logic               rst_n;
  logic               cmd_valid;
  logic               cmd_ready;
  logic [7:0]         cmd_op;
  logic [7:0]         cmd_addr;
  logic [15:0]        cmd_data;
  logic [5:0]         cmd_bits;
  logic               rsp_valid;
  logic [31:0]        rsp_word;
  logic               exec_ready;
  logic               exec_pulse;
  scsp_pkg::scsp_op_t exec_kind;
  logic [7:0]         exec_addr;
  logic [15:0]        exec_data;
  logic               seen;
  int                 n_errors;
  int                 n_tests;

  scsp_if link_if ();

  scsp_master scsp_master_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(link_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_bits(cmd_bits), .rsp_valid(rsp_valid), .rsp_word(rsp_word));

  scsp_slave scsp_slave_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(link_if),
    .exec_ready(exec_ready), .exec_pulse(exec_pulse), .exec_kind(exec_kind),
    .exec_addr(exec_addr), .exec_data(exec_data));

  scsp_link_asserts scsp_link_asserts_inst (.clk(clk), .rst_n(rst_n), .sclk(link_if.sclk),
    .cs_n(link_if.cs_n), .sdi(link_if.sdi), .sdo(link_if.sdo));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // --------
  // Helpers
  // --------
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Frames run about 26000 clk, so the response wait is bounded well above that
  task automatic send(input logic [7:0] op, input logic [7:0] addr, input logic [15:0] data,
                      input logic [5:0] bits);
    int i;
    i = 0;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #1;
      i++;
      if (i > 2000) begin
        n_errors++;
        stop_test();
      end
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_addr  <= addr;
    cmd_data  <= data;
    cmd_bits  <= bits;
    @(posedge clk);
    cmd_valid <= 1'b0;
    i = 0;
    while (rsp_valid !== 1'b1) begin
      @(posedge clk);
      #1;
      i++;
      if (i > 30000) begin
        n_errors++;
        stop_test();
      end
    end
  endtask

  task automatic wait_exec(output logic hit);
    hit = 1'b0;
    for (int i = 0; i < 20 && !hit; i++) begin
      @(posedge clk);
      #1;
      hit = (exec_pulse === 1'b1);
    end
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_reg_write();
    @(posedge clk);
    exec_ready <= 1'b0;
    send(8'h50, 8'h03, 16'ha5c3, 6'h20);
    chk_word(rsp_word, {8'h00, 8'h50, 8'h03, 8'ha5});
    wait_exec(seen);
    chk_bit(seen, 1'b0);
    @(posedge clk);
    exec_ready <= 1'b1;
    wait_exec(seen);
    chk_bit(seen, 1'b1);
    chk_word({5'h00, exec_kind, exec_addr, exec_data},
             {5'h00, scsp_pkg::scsp_reg_write_op, 8'h03, 16'ha5c3});
  endtask

  task automatic t_abort();
    send(8'h50, 8'h03, 16'h5a5a, 6'h10);
    wait_exec(seen);
    chk_bit(seen, 1'b0);
  endtask

  task automatic t_reg_read();
    send(8'h48, 8'h03, 16'h1234, 6'h20);
    chk_word(rsp_word, {8'h00, 8'h48, 16'ha5c3});
    wait_exec(seen);
    chk_bit(seen, 1'b1);
    chk_word({29'h0, exec_kind}, {29'h0, scsp_pkg::scsp_reg_read_op});
  endtask

  task automatic t_mem_write();
    send(8'h10, 8'h05, 16'h0f0f, 6'h20);
    chk_word(rsp_word, {8'h00, 8'h10, 8'h05, 8'h0f});
    wait_exec(seen);
    chk_bit(seen, 1'b1);
    chk_word({5'h00, exec_kind, exec_addr, exec_data},
             {5'h00, scsp_pkg::mem_word_write_op, 8'h05, 16'h0f0f});
  endtask

  initial begin
    n_errors   = 0;
    n_tests    = 0;
    rst_n      = 1'b0;
    cmd_valid  = 1'b0;
    cmd_op     = 8'h00;
    cmd_addr   = 8'h00;
    cmd_data   = 16'h0000;
    cmd_bits   = 6'h00;
    exec_ready = 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reg_write();
    t_abort();
    t_reg_read();
    t_mem_write();
    stop_test();
  end
endmodule
`default_nettype wire
